/* File: verilog/hub_port_disable_consts.vh */
`ifndef HUB_PORT_DISABLE_CONSTS_VH
`define HUB_PORT_DISABLE_CONSTS_VH

// register indices as printed, byte address is four times the index
`define SELF_MASK_INDEX        8'hE8
`define BUS_MASK_INDEX         8'hE9
`define CONTROL_INDEX          8'hF0
`define STATUS_INDEX           8'hF1
`define SELF_MASK_ADDR         12'h03A0
`define BUS_MASK_ADDR          12'h03A4
`define CONTROL_ADDR           12'h03C0
`define STATUS_ADDR            12'h03C4

`define MASK_RESET             8'h00
`define CONTROL_RESET          2'b00

// mask bits that control physical ports 3..1
`define MASK_PORT_HI           3
`define MASK_PORT_LO           1

// control register fields
`define CTRL_STRAP_SELECT_BIT  0
`define CTRL_REMAP_SELECT_BIT  1

// status register fields
`define STAT_HIDDEN_LO         0
`define STAT_COUNT_LO          4
`define STAT_P2L_LO            8
`define STAT_L2P_LO            16
`define STAT_POWER_BIT         24

`define RESP_OKAY              2'b00
`define RESP_DECERR            2'b11

`endif

/* File: verilog/hub_port_disable_config.v */
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "hub_port_disable_consts.vh"

// Overview of operation
// - an 8-bit register holds the mask of ports removed from service in self-powered operation.
// - a mask bit of one disables its port and a bit of zero leaves it available.
// - a disabled port is flagged hidden so the hub never lets the host enable or enumerate it.
// - any set of ports may be disabled and the reported port count equals the ports left enabled.
// - the remaining active ports are renumbered so the host sees a working port list.
// - mask bits 3, 2 and 1 control physical ports 3, 2 and 1 while bits 7 to 4 and 0 have no effect.
// - the self-powered mask sits at configuration index E8h.
// - a bus-powered mask with the same encoding sits at configuration index E9h.
// - with the internal default option selected the two strap pins choose the disabled ports instead.
// - with remapping off ports are reported in physical order with higher ports shifted down.
module hub_port_disable_config #(
   parameter ADDR_W = 12
) (
   input  wire              sys_clk,
   input  wire              reset_n,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire              self_powered,
   input  wire [1:0]        port_off_strap_pins,
   output reg  [2:0]        port_hidden,
   output reg  [1:0]        enabled_port_count,
   output reg  [5:0]        phys_to_logical,
   output reg  [5:0]        logical_to_phys,
   output reg               port_remap_select
);

   reg  [7:0]        self_power_port_off_mask;
   reg  [7:0]        bus_power_port_off_mask;
   reg               strap_select;
   reg  [1:0]        strap_latch;
   reg               strap_taken;
   reg  [ADDR_W-1:0] wr_addr;
   reg  [7:0]        wr_data;
   reg               wr_lane0;
   reg  [7:0]        power_mask;
   reg  [2:0]        next_hidden;
   reg  [1:0]        next_count;
   reg  [5:0]        next_p2l;
   reg  [5:0]        next_l2p;
   reg  [31:0]       read_word;
   reg  [1:0]        read_resp;
   integer           i;
   integer           n;

   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire  = s_axi_wvalid & s_axi_wready;
   wire do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire [31:0] status_word = {7'd0, self_powered, 2'd0, logical_to_phys, 2'd0, phys_to_logical,
                              2'd0, enabled_port_count, 1'b0, port_hidden};

   // straps are caught once, on the first edge after reset release
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_latch <= 2'b00;
         strap_taken <= 1'b0;
      end else if (!strap_taken) begin
         strap_latch <= port_off_strap_pins;
         strap_taken <= 1'b1;
      end
   end

   // effective disable set and port numbering
   always @* begin
      power_mask = self_powered ? self_power_port_off_mask : bus_power_port_off_mask;
      if (strap_select)
         next_hidden = {strap_latch, 1'b0};
      else
         next_hidden = power_mask[`MASK_PORT_HI:`MASK_PORT_LO];
      next_p2l = 6'd0;
      next_l2p = 6'd0;
      n = 0;
      for (i = 1; i <= 3; i = i + 1) begin
         if (!next_hidden[i-1]) begin
            n = n + 1;
            next_p2l[2*(i-1) +: 2] = n[1:0];
            next_l2p[2*(n-1) +: 2] = i[1:0];
         end
      end
      next_count = n[1:0];
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_hidden        <= 3'b000;
         enabled_port_count <= 2'd0;
         phys_to_logical    <= 6'd0;
         logical_to_phys    <= 6'd0;
      end else begin
         port_hidden        <= next_hidden;
         enabled_port_count <= next_count;
         phys_to_logical    <= next_p2l;
         logical_to_phys    <= next_l2p;
      end
   end

   // write channel: address and data taken in either order, response after both
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready            <= 1'b1;
         s_axi_wready             <= 1'b1;
         s_axi_bvalid             <= 1'b0;
         s_axi_bresp              <= `RESP_OKAY;
         wr_addr                  <= {ADDR_W{1'b0}};
         wr_data                  <= 8'h00;
         wr_lane0                 <= 1'b0;
         self_power_port_off_mask <= `MASK_RESET;
         bus_power_port_off_mask  <= `MASK_RESET;
         strap_select             <= 1'b0;
         port_remap_select        <= 1'b0;
      end else begin
         if (aw_fire) begin
            wr_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_fire) begin
            wr_data      <= s_axi_wdata[7:0];
            wr_lane0     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `RESP_OKAY;
            if (wr_addr == `SELF_MASK_ADDR) begin
               if (wr_lane0)
                  self_power_port_off_mask <= wr_data;
            end else if (wr_addr == `BUS_MASK_ADDR) begin
               if (wr_lane0)
                  bus_power_port_off_mask <= wr_data;
            end else if (wr_addr == `CONTROL_ADDR) begin
               if (wr_lane0) begin
                  strap_select      <= wr_data[`CTRL_STRAP_SELECT_BIT];
                  port_remap_select <= wr_data[`CTRL_REMAP_SELECT_BIT];
               end
            end else if (wr_addr == `STATUS_ADDR) begin
               s_axi_bresp <= `RESP_OKAY;
            end else begin
               s_axi_bresp <= `RESP_DECERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // read decode
   always @* begin
      read_resp = `RESP_OKAY;
      if (s_axi_araddr == `SELF_MASK_ADDR)
         read_word = {24'd0, self_power_port_off_mask};
      else if (s_axi_araddr == `BUS_MASK_ADDR)
         read_word = {24'd0, bus_power_port_off_mask};
      else if (s_axi_araddr == `CONTROL_ADDR)
         read_word = {30'd0, port_remap_select, strap_select};
      else if (s_axi_araddr == `STATUS_ADDR)
         read_word = status_word;
      else begin
         read_word = 32'h0000_0000;
         read_resp = `RESP_DECERR;
      end
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= read_word;
         s_axi_rresp   <= read_resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule
`default_nettype wire

/* File: bench/hub_port_disable_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module hub_port_disable_checker (
   input wire       sys_clk,
   input wire       reset_n,
   input wire       s_axi_awvalid,
   input wire       s_axi_awready,
   input wire       s_axi_wvalid,
   input wire       s_axi_wready,
   input wire       s_axi_bvalid,
   input wire       s_axi_bready,
   input wire       s_axi_arvalid,
   input wire       s_axi_arready,
   input wire       s_axi_rvalid,
   input wire       s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [2:0] port_hidden,
   input wire [1:0] enabled_port_count,
   input wire [5:0] phys_to_logical,
   input wire [5:0] logical_to_phys
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data unstable");
   a_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write taken early");
   a_count_match: assert property ($past(reset_n, 2) |-> enabled_port_count == 3 - $countones(port_hidden))
      else $error("port count wrong");
   a_hidden_slot: assert property ($past(reset_n, 2) |-> (port_hidden[0] == (phys_to_logical[1:0] == 0))
      && (port_hidden[1] == (phys_to_logical[3:2] == 0)) && (port_hidden[2] == (phys_to_logical[5:4] == 0)))
      else $error("hidden port numbered");
   a_first_slot: assert property ($past(reset_n, 2) && enabled_port_count != 0 |-> logical_to_phys[1:0]
      == (!port_hidden[0] ? 2'd1 : !port_hidden[1] ? 2'd2 : 2'd3))
      else $error("first logical port wrong");
endmodule
`default_nettype wire

/* File: bench/host_enum_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_enum_model (
   input wire logic       sys_clk,
   input wire logic [1:0] enabled_port_count,
   input wire logic [5:0] logical_to_phys,
   input wire logic [2:0] port_hidden,
   output var logic       hidden_seen = 1'b0
);
   integer j;
   // host walks each reported slot; an empty slot or one leading to a hidden port is flagged
   always @(posedge sys_clk)
      for (j = 0; j < 3; j++)
         if (j < enabled_port_count && (logical_to_phys[2*j+:2] == 0 || port_hidden[logical_to_phys[2*j+:2]-1]))
            hidden_seen <= 1'b1;
endmodule
`default_nettype wire

/* File: bench/test_hub_port_disable_config.sv */
`timescale 1ns/10ps
`default_nettype none
module test_hub_port_disable_config;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        sys_clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, self_powered = 1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, port_remap_select, hidden_seen;
   logic [1:0]  s_axi_bresp, s_axi_rresp, enabled_port_count, port_off_strap_pins = 2'b10;
   logic [2:0]  port_hidden;
   logic [5:0]  phys_to_logical, logical_to_phys;
   integer      err_total = 0, compares = 0, i;
   hub_port_disable_config u_hub_port_disable_config (.*);
   host_enum_model u_host_enum_model (.*);
   initial forever #25 sys_clk = ~sys_clk;
   task chk(input [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task results;
      $display("errors=%0d compares=%0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task wr(input [11:0] a, input [31:0] d, input [1:0] r);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(s_axi_bresp, r);
   endtask
   task rd(input [11:0] a, input [31:0] e, input [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask
   function [16:0] ex(input [2:0] h);
      integer k, n;
      reg [5:0] p, l;
      begin
         n = 0;
         p = 0;
         l = 0;
         for (k = 0; k < 3; k++)
            if (!h[k]) begin
               n++;
               p[2*k+:2] = n[1:0];
               l[2*n-2+:2] = 2'(k + 1);
            end
         ex = {l, p, n[1:0], h};
      end
   endfunction
   task port_chk(input [2:0] h);
      repeat (3) @(posedge sys_clk);
      chk({logical_to_phys, phys_to_logical, enabled_port_count, port_hidden}, ex(h));
   endtask
   task t_reset;
      rd(12'h03a0, 0, 0);
      rd(12'h03a4, 0, 0);
      port_chk(3'b000);
   endtask
   task t_masks;
      for (i = 0; i < 8; i++) begin
         wr(12'h03a0, {4'ha, i[2:0], 1'b1}, 0);
         wr(12'h03a4, {~i[2:0], 1'b0}, 0);
         rd(12'h03a0, {4'ha, i[2:0], 1'b1}, 0);
         self_powered <= 1;
         port_chk(i[2:0]);
         self_powered <= 0;
         port_chk(~i[2:0]);
      end
   endtask
   task t_strap;
      wr(12'h03c0, 1, 0);
      port_chk(3'b100);
      wr(12'h03c0, 2, 0);
      chk(port_remap_select, 1);
      rd(12'h03c0, 2, 0);
      port_chk(3'b000);
      self_powered <= 1;
      wr(12'h03a0, 32'h0000_000c, 0);
      port_chk(3'b110);
      rd(12'h03c4, 32'h0101_0116, 0);
   endtask
   task t_unmapped;
      wr(12'h0100, 32'h0000_00ff, 3);
      rd(12'h0100, 0, 3);
      rd(12'h03a4, 32'h0000_0000, 0);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1;
      t_reset;
      t_masks;
      t_strap;
      t_unmapped;
      chk(hidden_seen, 0);
      results;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      results;
   end
endmodule
bind hub_port_disable_config hub_port_disable_checker u_hub_port_disable_checker (.*);
`default_nettype wire
